// >>> common/bus_bridge_defs.vh
/*
  Constants for the mixed-speed bus bridge: code byte patterns, timing figures
  and the cycle counts derived from them at the 25 MHz sampling clock.
  Assumes the includer runs on that clock and uses no other definitions.
*/
// Overview of operation
// - Without master code, stay joined, source off
// - Detect code from any master on bus
// - Open data gate first, then pull SDA
// - Open clock gate when both clocks high
// - Hold SCL high, SDA low during high-speed
// - Source off after every acknowledge bit
// - Source on once SCLH released and high
// - SCL low one microsecond forces reconnect
// - STOP returns whole bus to slow mode
// - Source off when STOP seen on SDAH
// - On STOP close clock gate, both high
// - After STOP release SDA pull-down
// - Release pull-down fast for bus free
// - Close data gate once SDA is high
// - Both gates closed within bus free time
// - Switch fast; keep slow-mode timing on SDA/SCL
// - Devices keep pace or stretch clock
// - Input filters reject pulses to 50 ns
// - Reserved code keeps bridge closed, slow
// - Bus free time taken as 1.3 us
`ifndef BUS_BRIDGE_DEFS_VH
`define BUS_BRIDGE_DEFS_VH

`define CLK_PERIOD_NS 40
`define CODE_MASK 8'hF8
`define CODE_HS 8'h08
`define SPIKE_NS 50
`define SPIKE_CYC (((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define RECOVER_NS 1000
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUF_NS 1300
`define BUF_CYC (`BUF_NS / `CLK_PERIOD_NS)

`endif

// >>> rtl/mixed_speed_bus_bridge.v
/*
  Bridge control between a high-speed section (SDAH/SCLH) and a slow section
  (SDA/SCL). Watches all four lines, sampled on clk, and drives the two
  transfer gates, the slow data pull-down and the master current source.
  The gates and the pull-down are enables for open-drain switches outside
  this block; the block itself never drives a bus line.
  Assumes the lines arrive asynchronously and that hsAckDone is a pulse from
  the local master logic on clk marking the end of each acknowledge bit.
  Assumes activeMaster is a level from the same logic, high while the local
  master has won the code byte arbitration.
*/
`timescale 1ns/100ps
`include "bus_bridge_defs.vh"

module mixed_speed_bus_bridge (
  input wire clk,                  // 25 MHz sampling clock
  input wire srst,                 // Synchronous reset, active high
  input wire sdaHIn,               // High-speed data line level
  input wire sclHIn,               // High-speed clock line level
  input wire sdaIn,                // Slow data line level
  input wire sclIn,                // Slow clock line level
  input wire hsAckDone,            // Local master ack bit done, pulse
  input wire activeMaster,         // Local master owns the bus, level
  output reg dataTransferGate,     // High joins SDAH and SDA
  output reg clockTransferGate,    // High joins SCLH and SCL
  output reg slowDataPulldown,     // High drives SDA low
  output reg masterCurrentSource,  // High enables SCLH current source
  output reg highSpeedMode         // Bridge split for high-speed transfer
);

  localparam ST_JOIN = 3'd0;
  localparam ST_SPLIT_DATA = 3'd1;
  localparam ST_WAIT_CLK = 3'd2;
  localparam ST_HS = 3'd3;
  localparam ST_RELEASE = 3'd4;

  // Decodes of the next state used by the output registers and the current source
  function in_hs_phase;
    input [2:0] st;
    begin
      in_hs_phase = (st == ST_HS);
    end
  endfunction

  function slow_parked;
    input [2:0] st;
    begin
      // SDA held low from the clock hand-over wait up to the STOP
      slow_parked = (st == ST_WAIT_CLK) || (st == ST_HS);
    end
  endfunction

  function clock_joined;
    input [2:0] st;
    begin
      // Clock gate opens only for the high-speed phase itself
      clock_joined = (st != ST_HS);
    end
  endfunction

  // Filter step: count of samples that disagree with the level taken
  function [2:0] filt_count;
    input [2:0] cnt;
    input differs;
    begin
      if (!differs || cnt == (`SPIKE_CYC - 1))
        filt_count = 3'h0;
      else
        filt_count = cnt + 3'h1;
    end
  endfunction

  // Two-flop synchronisers; second stage only feeds the filters.
  // Preset high so a released bus gives no false edge after reset.
  reg [3:0] meta;
  reg [3:0] sync;
  always @(posedge clk) begin
    if (srst) begin
      meta <= 4'hF;
      sync <= 4'hF;
    end else begin
      meta <= {sdaHIn, sclHIn, sdaIn, sclIn};
      sync <= meta;
    end
  end

  // Spike filters: a new level must persist SPIKE_CYC samples, so short
  // pulses never reach the decoders; the price is a few cycles of latency
  reg sdaH;
  reg sclH;
  reg sdaL;
  reg sclL;
  reg [2:0] sdaHCnt;
  reg [2:0] sclHCnt;
  reg [2:0] sdaLCnt;
  reg [2:0] sclLCnt;

  // High-speed data line
  always @(posedge clk) begin
    if (srst) begin
      sdaH <= 1'b1;
      sdaHCnt <= 3'h0;
    end else begin
      sdaHCnt <= filt_count(sdaHCnt, sync[3] != sdaH);
      if (sync[3] != sdaH && sdaHCnt == (`SPIKE_CYC - 1))
        sdaH <= sync[3];
    end
  end

  // High-speed clock line
  always @(posedge clk) begin
    if (srst) begin
      sclH <= 1'b1;
      sclHCnt <= 3'h0;
    end else begin
      sclHCnt <= filt_count(sclHCnt, sync[2] != sclH);
      if (sync[2] != sclH && sclHCnt == (`SPIKE_CYC - 1))
        sclH <= sync[2];
    end
  end

  // Slow data line
  always @(posedge clk) begin
    if (srst) begin
      sdaL <= 1'b1;
      sdaLCnt <= 3'h0;
    end else begin
      sdaLCnt <= filt_count(sdaLCnt, sync[1] != sdaL);
      if (sync[1] != sdaL && sdaLCnt == (`SPIKE_CYC - 1))
        sdaL <= sync[1];
    end
  end

  // Slow clock line
  always @(posedge clk) begin
    if (srst) begin
      sclL <= 1'b1;
      sclLCnt <= 3'h0;
    end else begin
      sclLCnt <= filt_count(sclLCnt, sync[0] != sclL);
      if (sync[0] != sclL && sclLCnt == (`SPIKE_CYC - 1))
        sclL <= sync[0];
    end
  end

  // Edge history of the filtered high-speed lines; START and STOP are
  // data edges while the clock is high, seen from any master on the bus
  reg sdaHPrev;
  reg sclHPrev;
  always @(posedge clk) begin
    if (srst) begin
      sdaHPrev <= 1'b1;
      sclHPrev <= 1'b1;
    end else begin
      sdaHPrev <= sdaH;
      sclHPrev <= sclH;
    end
  end

  wire startSeen = sdaHPrev & ~sdaH & sclH;
  wire stopSeen = ~sdaHPrev & sdaH & sclH;
  wire sclRise = ~sclHPrev & sclH;

  // Code byte shifter, shared by every master on the bus
  reg [3:0] bitCnt;
  reg [7:0] codeByte;
  reg codeValid;
  always @(posedge clk) begin
    if (srst) begin
      bitCnt <= 4'hF;
      codeByte <= 8'h00;
      codeValid <= 1'b0;
    end else if (startSeen) begin
      bitCnt <= 4'h0;
      codeValid <= 1'b0;
    end else if (stopSeen) begin
      bitCnt <= 4'hF;
      codeValid <= 1'b0;
    end else if (sclRise && bitCnt < 4'h8) begin
      codeByte <= {codeByte[6:0], sdaH};
      bitCnt <= bitCnt + 4'h1;
      codeValid <= (bitCnt == 4'h7);
    end else begin
      codeValid <= 1'b0;
    end
  end

  // Only the 0000 1XXX pattern splits; reserved codes keep the bus joined
  function is_hs_code;
    input [7:0] b;
    begin
      is_hs_code = ((b & `CODE_MASK) == `CODE_HS);
    end
  endfunction
  wire hsCode = codeValid && is_hs_code(codeByte);

  // Recovery timer: counts while slow SCL is low, cleared while high.
  // Measured after the filter, so the forced rejoin lands a few cycles
  // later than the raw low time; still well inside a hang recovery.
  reg [5:0] recCnt;
  reg recover;
  always @(posedge clk) begin
    if (srst || sclL) begin
      recCnt <= 6'h00;
      recover <= 1'b0;
    end else if (recCnt == (`RECOVER_CYC - 1)) begin
      recover <= 1'b1;
    end else begin
      recCnt <= recCnt + 6'h01;
    end
  end

  // Bus free timer bounds the reconnect after STOP
  reg [5:0] bufCnt;
  reg [2:0] state;
  reg [2:0] next_state;
  always @(posedge clk) begin
    if (srst || state != ST_RELEASE)
      bufCnt <= 6'h00;
    else if (bufCnt != 6'h3F)
      bufCnt <= bufCnt + 6'h01;
  end
  wire bufOver = (bufCnt >= (`BUF_CYC - 2));

  // The hand-over waits for the clock pulse of the NACK after the code
  // byte, so the slow devices still see a complete ninth clock
  reg nackClock;
  always @(posedge clk) begin
    if (srst || state == ST_JOIN)
      nackClock <= 1'b0;
    else if (state == ST_WAIT_CLK && sclRise)
      nackClock <= 1'b1;
  end

  // Bridge sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_JOIN: begin
        if (hsCode)
          next_state = ST_SPLIT_DATA;
      end
      ST_SPLIT_DATA:
        next_state = ST_WAIT_CLK; // data gate opened a cycle earlier
      ST_WAIT_CLK: begin
        // A stretched slow clock simply delays the hand-over
        if (nackClock && sclH && sclL)
          next_state = ST_HS;
      end
      ST_HS: begin
        if (stopSeen)
          next_state = ST_RELEASE;
      end
      ST_RELEASE: begin
        if (sdaL || bufOver)
          next_state = ST_JOIN;
      end
      default:
        next_state = ST_JOIN;
    endcase
    if (recover && state != ST_JOIN)
      next_state = ST_JOIN;
  end

  always @(posedge clk) begin
    if (srst)
      state <= ST_JOIN;
    else
      state <= next_state;
  end

  // Next output values; the data gate leads the pull-down by a cycle on the
  // way in and trails it on the way out after STOP, switching with it on a forced rejoin, so the sections never fight
  reg next_dataTransferGate;
  reg next_clockTransferGate;
  reg next_slowDataPulldown;
  reg next_highSpeedMode;
  always @* begin
    next_dataTransferGate = (next_state == ST_JOIN);
    next_clockTransferGate = clock_joined(next_state);
    next_slowDataPulldown = slow_parked(next_state);
    next_highSpeedMode = (next_state != ST_JOIN);
  end

  // One cycle from decision to switch, far inside the slow-mode margins;
  // gates close with the lines high, except on bus free timeout or on a forced rejoin with SCL low
  always @(posedge clk) begin
    if (srst) begin
      dataTransferGate <= 1'b1;
      clockTransferGate <= 1'b1;
      slowDataPulldown <= 1'b0;
      highSpeedMode <= 1'b0;
    end else begin
      dataTransferGate <= next_dataTransferGate;
      clockTransferGate <= next_clockTransferGate;
      slowDataPulldown <= next_slowDataPulldown;
      highSpeedMode <= next_highSpeedMode;
    end
  end

  // Current source: off after ack or STOP, back on once SCLH is high again.
  // Only the winning master may run it; a losing one stays passive.
  reg srcHold;
  reg next_srcHold;
  reg next_masterCurrentSource;
  always @* begin
    next_srcHold = srcHold;
    next_masterCurrentSource = masterCurrentSource;
    if (!in_hs_phase(next_state) || !activeMaster || stopSeen) begin
      next_masterCurrentSource = 1'b0;
      next_srcHold = 1'b0;
    end else if (hsAckDone) begin
      next_masterCurrentSource = 1'b0;
      next_srcHold = 1'b1;
    end else if (srcHold) begin
      if (sclRise) begin
        next_masterCurrentSource = 1'b1;
        next_srcHold = 1'b0;
      end
    end else begin
      next_masterCurrentSource = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      masterCurrentSource <= 1'b0;
      srcHold <= 1'b0;
    end else begin
      masterCurrentSource <= next_masterCurrentSource;
      srcHold <= next_srcHold;
    end
  end

endmodule

// >>> bench/bridge_properties.sv
/* Assertions on the bridge outputs.
   Sees only the bridge ports; bound into every bridge instance. */
`timescale 1ns/100ps
module bridge_properties (
  input wire clk, // Clock
  input wire srst, // Reset
  input wire sdaHIn, // Hs data
  input wire sclHIn, // Hs clock
  input wire sdaIn, // Slow data
  input wire sclIn, // Slow clock
  input wire hsAckDone, // Ack end
  input wire activeMaster, // Owner
  input wire dataTransferGate, // Data gate
  input wire clockTransferGate, // Clock gate
  input wire slowDataPulldown, // Pull-down
  input wire masterCurrentSource, // Source
  input wire highSpeedMode // Split
);
  reg [5:0] lowRun; // SCL low cycles, saturates
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Raw low time, so the rejoin bound also covers the filter delay
  always @(posedge clk) begin
    if (srst || sclIn) lowRun <= 6'h00;
    else if (lowRun != 6'h3F) lowRun <= lowRun + 6'h01;
  end
  reset_state_a: assert property ($fell(srst) |-> dataTransferGate && clockTransferGate
    && !slowDataPulldown && !masterCurrentSource && !highSpeedMode) else $error("bad reset state");
  idle_joined_a: assert property (!highSpeedMode |-> dataTransferGate && clockTransferGate
    && !slowDataPulldown && !masterCurrentSource) else $error("not joined");
  split_order_a: assert property ($fell(dataTransferGate) |-> !slowDataPulldown ##1 slowDataPulldown)
    else $error("split order");
  clock_split_a: assert property ($fell(clockTransferGate) |-> slowDataPulldown && highSpeedMode)
    else $error("clock split early");
  ack_source_a: assert property (hsAckDone |=> !masterCurrentSource) else $error("source after ack");
  source_owner_a: assert property (masterCurrentSource |-> activeMaster && !clockTransferGate)
    else $error("source not owned");
  stop_rejoin_a: assert property ($rose(clockTransferGate) |-> !slowDataPulldown && !masterCurrentSource
    ##[0:32] dataTransferGate) else $error("slow rejoin");
  recover_a: assert property (lowRun == 6'h28 |-> dataTransferGate && clockTransferGate
    && !slowDataPulldown) else $error("no recovery");
endmodule
bind mixed_speed_bus_bridge bridge_properties i_bridge_properties (.*);

// >>> bench/bus_lines_model.sv
/* Wired-AND levels of both bus sections around the bridge.
   Assumes pull-ups on all four lines and no slow data driver. */
`timescale 1ns/100ps
module bus_lines_model (
  input wire hsSda, // Hs devices data drive
  input wire hsScl, // Hs devices clock drive
  input wire fsScl, // Slow device clock drive
  input wire dataTransferGate, // Data gate
  input wire clockTransferGate, // Clock gate
  input wire slowDataPulldown, // SDA pull-down
  output wire sdaHIn, // SDAH level
  output wire sclHIn, // SCLH level
  output wire sdaIn, // SDA level
  output wire sclIn // SCL level
);
  // A closed clock gate passes lows both ways, the data gate SDAH to SDA only; released lines float high
  assign sdaIn = ~slowDataPulldown & (~dataTransferGate | hsSda);
  assign sdaHIn = hsSda;
  assign sclHIn = hsScl & (~clockTransferGate | fsScl);
  assign sclIn = fsScl & (~clockTransferGate | hsScl);
endmodule

// >>> bench/tb_mixed_speed_bus_bridge.sv
/* Bench for the bridge: drives the lines through the bus model.
   Assumes a 25 MHz clock and a 320 ns code clock. */
`timescale 1ns/100ps
module tb_mixed_speed_bus_bridge;
  logic clk = 0, srst = 1, hsSda = 1, hsScl = 1, fsScl = 1, hsAckDone = 0, activeMaster = 1;
  wire sdaHIn, sclHIn, sdaIn, sclIn, dataTransferGate, clockTransferGate;
  wire slowDataPulldown, masterCurrentSource, highSpeedMode;
  int fails = 0, checks = 0, cyc = 0;
  always #20 clk = ~clk;
  mixed_speed_bus_bridge i_mixed_speed_bus_bridge (.*);
  bus_lines_model i_bus_lines_model (.*);
  task chk(string n, logic s, logic e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %b seen %b", n, e, s);
    end
  endtask
  task finish_test;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task hb(int n = 4);
    repeat (n) @(negedge clk);
  endtask
  task st(logic d, c, p, s, h);
    chk("dataGate", dataTransferGate, d);
    chk("clockGate", clockTransferGate, c);
    chk("pulldown", slowDataPulldown, p);
    chk("source", masterCurrentSource, s);
    chk("hsMode", highSpeedMode, h);
  endtask
  // START, code byte MSB first, then NACK, all at slow speed
  task code(logic [7:0] b);
    hsSda = 0;
    hb();
    for (int i = 7; i >= 0; i--) begin
      hsScl = 0;
      hsSda = b[i];
      hb();
      hsScl = 1;
      hb();
    end
    hsScl = 0;
    hsSda = 1;
    hb();
    hsScl = 1;
    hb(12);
  endtask
  // SDAH rises while SCLH high; long wait covers the bus free time
  task stop;
    hsScl = 0;
    hsSda = 0;
    hb();
    hsScl = 1;
    hb();
    hsSda = 1;
    hb(40);
  endtask
  // Hs transfer; only the winning master may run its source
  task hs_transfer(logic act);
    activeMaster = act;
    code(8'h0A);
    st(0, 0, 1, act, 1);
    chk("sclParked", sclIn, 1);
    chk("sdaParked", sdaIn, 0);
    hsSda = 0;
    hb();
    hsScl = 0;
    hb();
    hsScl = 1;
    hb(8); // Ack clock high long enough to pass the filter first
    hsScl = 0;
    hsAckDone = 1;
    hb(1);
    hsAckDone = 0;
    hb(1);
    chk("srcAck", masterCurrentSource, 0);
    hb(6);
    chk("srcStretch", masterCurrentSource, 0);
    hsScl = 1;
    hb(10);
    chk("srcHigh", masterCurrentSource, act);
    stop();
    st(1, 1, 0, 0, 0);
    chk("sdaFree", sdaIn, 1);
  endtask
  initial begin
    hb(3);
    st(1, 1, 0, 0, 0);
    srst = 0;
    hb(2);
    hs_transfer(1);
    hs_transfer(0);
    code(8'h05);
    st(1, 1, 0, 0, 0);
    stop();
    code(8'h0F);
    fsScl = 0;
    hb(40);
    st(1, 1, 0, 0, 0);
    fsScl = 1;
    stop();
    finish_test();
  end
  // Run takes under 1500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
endmodule
